// ---- rnbs_scheduler.sv ----
// Functional notes
// - slave buffers outbound messages until bid
// - master releases link while bid runs
// - slave sends oldest buffered message on bid
// - one message per received bid
// - empty slave ignores bid; master times out
// - slave answers every bid received in idle with a non-empty buffer, no hold-off
// - slave send window is reply timeout
// - link returns to master after transaction
// - writing drop to bid register bids it
// - 100+n sweeps drops n down to 0
// - bid, reply wait, interval, stop at zero
// - normal messages sent during bid interval
// - normal traffic pauses sequence, then resumes
// - 200+n bids drop n forever
// - 300+n sweeps, reloading after drop zero
// - interval paces bids, timeout bounds them
// - long reply timeout allows slave-to-slave
// - 100..199 selects the decrementing sweep
// - master disable bit stops master
// - retry unacked normal message up to limit
module rnbs_scheduler
  import rnbs_pkg::*;
#(
  parameter int TICK_CYCLES = UNIT_CYC
) (
  input  wire logic              clk,          // 125 MHz clock
  input  wire logic              rst,          // async reset, high
  input  wire logic              wb_cyc_i,     // wishbone cycle
  input  wire logic              wb_stb_i,     // wishbone strobe
  input  wire logic              wb_we_i,      // wishbone write
  input  wire logic [7:0]        wb_adr_i,     // byte address
  input  wire logic [3:0]        wb_sel_i,     // byte enables
  input  wire logic [31:0]       wb_dat_i,     // write data
  output logic      [31:0]       wb_dat_o,     // read data
  output logic                   wb_ack_o,     // acknowledge
  output logic                   bid_strobe,   // master: send bid, pulse
  output logic      [DROP_W-1:0] bid_drop,     // master: drop being bid
  output logic                   link_release, // master: link handed to slave
  input  wire logic              slv_done,     // granted transaction finished
  input  wire logic              norm_req,     // normal message queued
  output logic                   norm_go,      // master may send normal message
  input  wire logic              norm_ack,     // normal message acknowledged
  input  wire logic              norm_nak,     // no ack, pulse
  output logic                   norm_exhaust, // retries exhausted, pulse
  input  wire logic              rx_bid,       // slave: bid for this drop
  input  wire logic              loc_valid,    // local outbound message valid
  input  wire logic [MSG_W-1:0]  loc_data,     // local outbound message
  output logic                   loc_ready,    // buffer can accept
  output logic                   slv_tx_go,    // slave transmits as originator
  output logic      [MSG_W-1:0]  slv_tx_data,  // oldest buffered message
  input  wire logic              slv_tx_done   // slave transaction finished
);

  rnbs_state_type       state;
  rnbs_state_type       next_state;
  logic [BID_W-1:0]     bid_reg;
  logic [UNIT_W-1:0]    reply_to;
  logic [UNIT_W-1:0]    interval;
  logic [3:0]           retry_lim;
  logic [15:0]          options;
  logic [TICK_W-1:0]    tick_cnt;
  logic [UNIT_W-1:0]    units;
  logic                 seq_active;
  rnbs_mode_type        seq_mode;
  logic [DROP_W-1:0]    seq_drop;
  logic [DROP_W-1:0]    seq_start;
  logic                 new_flag;
  logic [BID_W-1:0]     new_val;
  logic [3:0]           tries;
  logic [MSG_W-1:0]     mem [BUF_DEPTH];
  logic [BUF_AW-1:0]    wr_ptr;
  logic [BUF_AW-1:0]    rd_ptr;
  logic [BUF_AW:0]      fill;
  logic [BUF_AW:0]      next_fill;
  logic                 wb_req;
  logic                 bid_wr;
  logic                 role_slave;
  logic                 mst_on;
  logic                 expired;
  logic                 seq_more;
  logic                 load_seq;
  logic                 advance;
  logic                 push;
  logic                 pop;
  logic                 norm_end;

  // value to mode: ranges of one hundred
  function automatic rnbs_mode_type mode_of(input logic [BID_W-1:0] v);
    if (v >= BID_CYCLE)
      return MD_CYCLE;
    else if (v >= BID_REPEAT)
      return MD_REPEAT;
    else if (v >= BID_SWEEP)
      return MD_SWEEP;
    else
      return MD_SINGLE;
  endfunction

  function automatic logic [DROP_W-1:0] drop_of(input logic [BID_W-1:0] v);
    logic [BID_W-1:0] d;
    d = v;
    if (v >= BID_CYCLE)
      d = v - BID_CYCLE;
    else if (v >= BID_REPEAT)
      d = v - BID_REPEAT;
    else if (v >= BID_SWEEP)
      d = v - BID_SWEEP;
    return d[DROP_W-1:0];
  endfunction

  assign wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bid_wr     = wb_req & wb_we_i & (wb_adr_i == REG_BID) & wb_sel_i[0] & wb_sel_i[1]
                      & (wb_dat_i[BID_W-1:0] < BID_LIMIT) & (wb_dat_i[31:BID_W] == '0);
  assign role_slave = options[OPT_SLAVE_BIT];
  assign mst_on     = ~role_slave & ~options[OPT_MDIS_BIT];
  assign expired    = (state == ST_INTERVAL) ? (units >= interval) : (units >= reply_to);
  // a sequence goes on unless single, or a plain sweep that has reached drop zero
  assign seq_more   = new_flag | ((seq_mode != MD_SINGLE) & ~((seq_mode == MD_SWEEP) & (seq_drop == '0)));
  assign load_seq   = new_flag & (((state == ST_IDLE) & (next_state == ST_BID))
                      | ((state == ST_REPLY) & (next_state != ST_REPLY)));
  assign advance    = ~new_flag & (state == ST_REPLY) & (next_state != ST_REPLY);
  assign norm_end   = norm_ack | (norm_nak & (tries >= retry_lim));
  assign push       = loc_valid & loc_ready;
  assign pop        = (state == ST_SL_TX) & slv_tx_done;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (role_slave) begin
          if (rx_bid && fill != '0)
            next_state = ST_SL_TX;
        end else if (mst_on) begin
          if (norm_req)
            next_state = ST_NORMAL;
          else if (seq_active || new_flag)
            next_state = ST_BID;
        end
      end
      ST_BID: begin
        next_state = ST_REPLY;
      end
      ST_REPLY: begin
        if (slv_done || expired)
          next_state = seq_more ? ST_INTERVAL : ST_IDLE;
      end
      ST_INTERVAL: begin
        if (norm_req)
          next_state = ST_NORMAL;
        else if (expired)
          next_state = ST_IDLE;
      end
      ST_NORMAL: begin
        if (norm_end)
          next_state = (seq_active || new_flag) ? ST_INTERVAL : ST_IDLE;
      end
      ST_SL_TX: begin
        if (slv_tx_done || expired)
          next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // a master disabled or turned slave mid-sequence drops back to idle
    if (state != ST_IDLE && state != ST_SL_TX && !mst_on)
      next_state = ST_IDLE;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // unit timer restarts on every state change
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt <= '0;
      units    <= '0;
    end else if (state != next_state) begin
      tick_cnt <= '0;
      units    <= '0;
    end else if (tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      if (units != '1)
        units <= units + 16'h0001;
    end else begin
      tick_cnt <= tick_cnt + 21'h000001;
    end
  end

  // sequence bookkeeping
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq_active <= 1'b0;
      seq_mode   <= MD_SINGLE;
      seq_drop   <= '0;
      seq_start  <= '0;
      new_flag   <= 1'b0;
      new_val    <= '0;
    end else begin
      if (load_seq) begin
        seq_active <= 1'b1;
        seq_mode   <= mode_of(new_val);
        seq_drop   <= drop_of(new_val);
        seq_start  <= drop_of(new_val);
        new_flag   <= 1'b0;
      end else if (advance) begin
        case (seq_mode)
          MD_SINGLE: begin
            seq_active <= 1'b0;
          end
          MD_SWEEP: begin
            if (seq_drop == '0)
              seq_active <= 1'b0;
            else
              seq_drop <= seq_drop - 7'h01;
          end
          MD_REPEAT: begin
            seq_drop <= seq_drop;
          end
          default: begin
            if (seq_drop == '0)
              seq_drop <= seq_start;
            else
              seq_drop <= seq_drop - 7'h01;
          end
        endcase
      end
      // a write in the load cycle still counts: set wins over clear
      if (bid_wr) begin
        new_flag <= 1'b1;
        new_val  <= wb_dat_i[BID_W-1:0];
      end
    end
  end

  // normal message retries
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tries        <= '0;
      norm_exhaust <= 1'b0;
    end else begin
      norm_exhaust <= (state == ST_NORMAL) & norm_nak & (tries >= retry_lim);
      if (state != ST_NORMAL)
        tries <= '0;
      else if (norm_nak && tries < retry_lim)
        tries <= tries + 4'h1;
    end
  end

  // link-facing outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bid_strobe   <= 1'b0;
      bid_drop     <= '0;
      link_release <= 1'b0;
      norm_go      <= 1'b0;
      slv_tx_go    <= 1'b0;
      slv_tx_data  <= '0;
    end else begin
      bid_strobe   <= (state == ST_BID);
      if (state == ST_BID)
        bid_drop <= seq_drop;
      link_release <= (next_state == ST_REPLY);
      norm_go      <= (next_state == ST_NORMAL);
      slv_tx_go    <= (next_state == ST_SL_TX);
      slv_tx_data  <= mem[rd_ptr];
    end
  end

  // slave outbound buffer, oldest first
  always_comb begin
    next_fill = fill;
    if (push && !pop)
      next_fill = fill + 4'h1;
    else if (pop && !push)
      next_fill = fill - 4'h1;
  end

  always_ff @(posedge clk) begin
    if (push)
      mem[wr_ptr] <= loc_data;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      fill      <= '0;
      loc_ready <= 1'b0;
    end else begin
      if (push)
        wr_ptr <= wr_ptr + 3'h1;
      if (pop)
        rd_ptr <= rd_ptr + 3'h1;
      fill      <= next_fill;
      loc_ready <= (next_fill != 4'(BUF_DEPTH));
    end
  end

  // register file
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bid_reg   <= '0;
      reply_to  <= RST_REPLY_TO;
      interval  <= RST_INTERVAL;
      retry_lim <= RST_RETRIES;
      options   <= RST_OPTIONS;
    end else if (wb_req && wb_we_i) begin
      if (bid_wr) begin
        bid_reg <= wb_dat_i[BID_W-1:0];
      end else if (wb_adr_i == REG_REPLY_TO) begin
        if (wb_sel_i[0])
          reply_to[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          reply_to[15:8] <= wb_dat_i[15:8];
      end else if (wb_adr_i == REG_INTERVAL) begin
        if (wb_sel_i[0])
          interval[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          interval[15:8] <= wb_dat_i[15:8];
      end else if (wb_adr_i == REG_RETRIES) begin
        if (wb_sel_i[0])
          retry_lim <= wb_dat_i[3:0];
      end else if (wb_adr_i == REG_OPTIONS) begin
        if (wb_sel_i[0])
          options[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          options[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= '0;
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == REG_BID)
          wb_dat_o <= {23'h000000, bid_reg};
        else if (wb_adr_i == REG_REPLY_TO)
          wb_dat_o <= {16'h0000, reply_to};
        else if (wb_adr_i == REG_INTERVAL)
          wb_dat_o <= {16'h0000, interval};
        else if (wb_adr_i == REG_RETRIES)
          wb_dat_o <= {28'h0000000, retry_lim};
        else if (wb_adr_i == REG_OPTIONS)
          wb_dat_o <= {16'h0000, options};
        else if (wb_adr_i == REG_STATUS)
          wb_dat_o <= {11'h000, state, 2'h0, seq_mode, seq_active, new_flag, fill, 1'b0, seq_drop};
      end
    end
  end

endmodule

// ---- rnbs_pkg.sv ----
package rnbs_pkg;

  // time base: all link timing is in 10 ms units
  localparam int UNIT_NS    = 10_000_000;
  localparam int CLK_NS     = 8;
  localparam int UNIT_CYC   = UNIT_NS / CLK_NS;
  localparam int TICK_W     = 21;
  localparam int UNIT_W     = 16;

  // register byte offsets
  localparam logic [7:0] REG_BID      = 8'h00;
  localparam logic [7:0] REG_REPLY_TO = 8'h04;
  localparam logic [7:0] REG_INTERVAL = 8'h08;
  localparam logic [7:0] REG_RETRIES  = 8'h0C;
  localparam logic [7:0] REG_OPTIONS  = 8'h10;
  localparam logic [7:0] REG_STATUS   = 8'h14;

  // reset values
  localparam logic [UNIT_W-1:0] RST_REPLY_TO = 16'h00C8;
  localparam logic [UNIT_W-1:0] RST_INTERVAL = 16'h0064;
  localparam logic [3:0]        RST_RETRIES  = 4'h3;
  localparam logic [15:0]       RST_OPTIONS  = 16'h0000;

  // option bits
  localparam int OPT_SLAVE_BIT = 0;
  localparam int OPT_MDIS_BIT  = 9;

  // bid value ranges
  localparam int          BID_W        = 9;
  localparam int          DROP_W       = 7;
  localparam logic [8:0]  BID_SWEEP    = 9'h064;
  localparam logic [8:0]  BID_REPEAT   = 9'h0C8;
  localparam logic [8:0]  BID_CYCLE    = 9'h12C;
  localparam logic [8:0]  BID_LIMIT    = 9'h190;

  // slave message buffer
  localparam int BUF_DEPTH = 8;
  localparam int BUF_AW    = 3;
  localparam int MSG_W     = 16;

  typedef enum logic [2:0] {
    ST_IDLE, ST_BID, ST_REPLY, ST_INTERVAL, ST_NORMAL, ST_SL_TX
  } rnbs_state_type;

  typedef enum logic [1:0] {
    MD_SINGLE, MD_SWEEP, MD_REPEAT, MD_CYCLE
  } rnbs_mode_type;

endpackage

// ---- rnbs_asserts.sv ----
module rnbs_asserts
  import rnbs_pkg::*;
#(
  parameter int TICK_CYCLES = UNIT_CYC
) (
  input wire logic              clk,          // clock
  input wire logic              rst,          // reset
  input wire logic              wb_cyc_i,     // cycle
  input wire logic              wb_stb_i,     // strobe
  input wire logic              wb_we_i,      // write
  input wire logic [7:0]        wb_adr_i,     // address
  input wire logic [31:0]       wb_dat_i,     // write data
  input wire logic              wb_ack_o,     // ack
  input wire logic              bid_strobe,   // bid sent
  input wire logic [DROP_W-1:0] bid_drop,     // bid drop
  input wire logic              link_release, // link handed off
  input wire logic              slv_done,     // reply done
  input wire logic              norm_go,      // normal send
  input wire logic              norm_nak,     // no ack
  input wire logic              norm_exhaust, // retries out
  input wire logic              slv_tx_go,    // slave sending
  input wire logic [MSG_W-1:0]  slv_tx_data,  // slave message
  input wire logic              slv_tx_done   // slave done
);
  logic [15:0] rto;
  int          run;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // timeout copied from bus writes so the bound follows software
  always_ff @(posedge clk or posedge rst)
    if (rst) rto <= RST_REPLY_TO;
    else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == REG_REPLY_TO)
      rto <= wb_dat_i[15:0];
  always_ff @(posedge clk or posedge rst)
    if (rst) run <= 0;
    else run <= link_release ? run + 1 : 0;
  property p_ack_once; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  property p_rel_bid; $rose(link_release) |-> bid_strobe; endproperty
  property p_bid_rel; bid_strobe |-> link_release; endproperty
  property p_bid_pulse; bid_strobe |=> !bid_strobe; endproperty
  property p_done_ends; link_release && slv_done && !bid_strobe |=> ##[0:2] !link_release; endproperty
  property p_rto; run <= int'(rto) * TICK_CYCLES + 4; endproperty
  property p_drop_hold; link_release && !bid_strobe |-> $stable(bid_drop); endproperty
  property p_norm_half; norm_go |-> !link_release; endproperty
  property p_exh; norm_exhaust |-> $past(norm_nak) || $past(norm_nak, 2); endproperty
  property p_tx_pop; slv_tx_go && slv_tx_done |=> !slv_tx_go; endproperty
  property p_tx_hold; slv_tx_go && $past(slv_tx_go) |-> $stable(slv_tx_data); endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack not one pulse");
  a_rel_bid: assert property (p_rel_bid) else $error("link freed without bid");
  a_bid_rel: assert property (p_bid_rel) else $error("bid with link held");
  a_bid_pulse: assert property (p_bid_pulse) else $error("bid strobe too long");
  a_done_ends: assert property (p_done_ends) else $error("link not returned");
  a_rto: assert property (p_rto) else $error("reply wait too long");
  a_drop_hold: assert property (p_drop_hold) else $error("drop moved in reply");
  a_norm_half: assert property (p_norm_half) else $error("normal send in bid");
  a_exh: assert property (p_exh) else $error("exhaust without nak");
  a_tx_pop: assert property (p_tx_pop) else $error("second message sent");
  a_tx_hold: assert property (p_tx_hold) else $error("message changed");
  c_bid0: cover property (bid_strobe && bid_drop == 7'h00);
  c_pop: cover property (slv_tx_go && slv_tx_done);
  c_exh: cover property (norm_exhaust);
endmodule

bind rnbs_scheduler rnbs_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

// ---- rnbs_link_model.sv ----
module rnbs_link_model (
  input  wire logic       clk,        // clock
  input  wire logic       rst,        // reset
  input  wire logic       bid_strobe, // bid on link
  input  wire logic [7:0] ans_dly,    // reply delay, 0 stays silent
  input  wire logic       nak_mode,   // never ack normal messages
  input  wire logic       norm_go,    // normal message on link
  input  wire logic       slv_tx_go,  // our slave sending
  output logic            slv_done,   // remote reply finished
  output logic            norm_ack,   // remote acked
  output logic            norm_nak,   // no ack
  output logic            slv_tx_done // master acked our message
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] bc;
  logic [1:0] nc;
  logic [1:0] sc;
  // silent delay models a remote with an empty buffer
  always_ff @(posedge clk or posedge rst)
    if (rst) bc <= 8'h00;
    else if (bid_strobe) bc <= ans_dly;
    else if (bc != 8'h00) bc <= bc - 8'h01;
  always_ff @(posedge clk or posedge rst)
    if (rst) slv_done <= 1'b0;
    else slv_done <= bc == 8'h01;
  always_ff @(posedge clk or posedge rst)
    if (rst) nc <= 2'h0;
    else nc <= (norm_go && nc != 2'h2) ? nc + 2'h1 : 2'h0;
  always_ff @(posedge clk or posedge rst)
    if (rst) norm_ack <= 1'b0;
    else norm_ack <= nc == 2'h2 && !nak_mode;
  always_ff @(posedge clk or posedge rst)
    if (rst) norm_nak <= 1'b0;
    else norm_nak <= nc == 2'h2 && nak_mode;
  always_ff @(posedge clk or posedge rst)
    if (rst) sc <= 2'h0;
    else sc <= (slv_tx_go && sc != 2'h2) ? sc + 2'h1 : 2'h0;
  always_ff @(posedge clk or posedge rst)
    if (rst) slv_tx_done <= 1'b0;
    else slv_tx_done <= sc == 2'h2;
endmodule

// ---- rnbs_scheduler_tb_top.sv ----
module rnbs_scheduler_tb_top
  import rnbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [8:0] val; logic [7:0] ans; int n; logic [6:0] first;} rnbs_row_type;
  logic             clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, bid_strobe, link_release;
  logic             slv_done, norm_req, norm_go, norm_ack, norm_nak, norm_exhaust, rx_bid;
  logic             loc_valid, loc_ready, slv_tx_go, slv_tx_done, nak_mode, saw_exh, saw_go;
  logic [3:0]       wb_sel_i;
  logic [7:0]       wb_adr_i, ans_dly;
  logic [31:0]      wb_dat_i, wb_dat_o, rd;
  logic [6:0]       bid_drop;
  logic [15:0]      loc_data, slv_tx_data;
  logic [6:0]       q[$];
  int               n_errors = 0, checked = 0, cyc = 0, rel_cnt = 0, rel_len = 0, n_nak = 0;
  rnbs_row_type     rows[4] = '{'{9'h005, 8'h00, 1, 7'h05}, '{9'h064, 8'h05, 1, 7'h00},
                                '{9'h067, 8'h00, 4, 7'h03}, '{9'h0C7, 8'h03, 100, 7'h63}};
  logic [7:0]       ra[5] = '{REG_REPLY_TO, REG_INTERVAL, REG_RETRIES, REG_OPTIONS, 8'h3C};
  logic [31:0]      rv[5] = '{32'h0000_00C8, 32'h0000_0064, 32'h0000_0003, 32'h0, 32'h0};

  rnbs_scheduler #(.TICK_CYCLES(4)) DUT (.*);
  rnbs_link_model u_far (.*);

  always #4 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (bid_strobe) q.push_back(bid_drop);
    if (norm_nak) n_nak <= n_nak + 1;
    if (norm_exhaust) saw_exh <= 1'b1;
    if (norm_go) saw_go <= 1'b1;
    rel_cnt <= link_release ? rel_cnt + 1 : 0;
    if (link_release) rel_len <= rel_cnt + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    @(posedge clk iff wb_ack_o);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask

  // quiet must outlast the interval between bids, or a sweep looks finished
  task automatic settle();
    int quiet = 0;
    while (quiet < 40) begin
      @(posedge clk);
      quiet = (bid_strobe || link_release || norm_go) ? 0 : quiet + 1;
    end
  endtask

  task automatic start(input logic [31:0] v, input int wait_n);
    q.delete();
    wb(1'b1, REG_BID, v);
    while (q.size() < wait_n) @(posedge clk);
  endtask

  initial begin
    {clk, wb_cyc_i, wb_stb_i, wb_we_i, norm_req, rx_bid, loc_valid, nak_mode} = '0;
    {wb_sel_i, wb_adr_i, wb_dat_i, loc_data, ans_dly, saw_exh, saw_go} = '0;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wb(1'b1, REG_REPLY_TO, 32'h3);
    wb(1'b1, REG_INTERVAL, 32'h2);
    foreach (rows[i]) begin
      ans_dly <= rows[i].ans;
      start({23'h0, rows[i].val}, 0);
      settle();
      chk("bid_count", q.size(), rows[i].n);
      foreach (q[j]) chk("bid_drop", q[j], 7'(rows[i].first - j));
      chk("rel_len", rows[i].ans ? rel_len inside {[rows[i].ans:rows[i].ans + 4]} :
          rel_len inside {[10:15]}, 1);
      $display("row %0d done", i);
    end
    ans_dly <= 8'h02;
    start(32'hCB, 3);
    wb(1'b1, REG_BID, 32'h5);
    settle();
    foreach (q[j]) chk("rep_drop", q[j], j == q.size() - 1 ? 5 : 3);
    start(32'h12E, 5);
    wb(1'b1, REG_BID, 32'h7);
    settle();
    foreach (q[j]) chk("cyc_drop", q[j], j == q.size() - 1 ? 7 : 2 - j % 3);
    $display("continuous done");
    start(32'h67, 1);
    norm_req <= 1'b1;
    @(posedge clk iff norm_ack);
    norm_req <= 1'b0;
    settle();
    chk("norm_sent", saw_go, 1);
    chk("sweep_len", q.size(), 4);
    wb(1'b1, REG_RETRIES, 32'h2);
    nak_mode <= 1'b1;
    norm_req <= 1'b1;
    @(posedge clk iff saw_exh);
    norm_req <= 1'b0;
    nak_mode <= 1'b0;
    chk("nak_count", n_nak, 3);
    $display("normal done");
    wb(1'b1, REG_OPTIONS, 32'h200);
    start(32'h5, 0);
    settle();
    chk("dis_bids", q.size(), 0);
    wb(1'b1, REG_OPTIONS, 32'h1);
    for (int i = 0; i < 8; i++) begin
      loc_valid <= 1'b1;
      loc_data <= 16'(16'h00A0 + i);
      @(posedge clk iff loc_ready);
    end
    loc_valid <= 1'b0;
    repeat (2) @(posedge clk);
    chk("buf_full", loc_ready, 0);
    for (int i = 0; i < 9; i++) begin
      rx_bid <= 1'b1;
      @(posedge clk);
      rx_bid <= 1'b0;
      @(posedge clk);
      chk("tx_go", slv_tx_go, i < 8);
      if (i < 8) chk("tx_data", slv_tx_data, 16'h00A0 + i);
      repeat (8) @(posedge clk);
      chk("tx_idle", slv_tx_go, 0);
    end
    $display("slave done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i]) begin
      wb(1'b0, ra[i], 32'h0);
      chk("reg_reset", rd, rv[i]);
    end
    $display("reset done");
    end_sim();
  end
endmodule
